// *** core/ttcu_defines.svh ***
// Purpose: register indices, field positions and reset values of the triple timer/counter unit
// Assumes: 32-bit AHB-Lite bus, one register per aligned word, byte address = index * 4
// Notes: indices are the printed special function register offsets
`ifndef TTCU_DEFINES_SVH
`define TTCU_DEFINES_SVH

// register indices
`define TTCU_IDX_T01_CTL 8'h88
`define TTCU_IDX_T01_MODE 8'h89
`define TTCU_IDX_T0_LOW 8'h8A
`define TTCU_IDX_T1_LOW 8'h8B
`define TTCU_IDX_T0_HIGH 8'h8C
`define TTCU_IDX_T1_HIGH 8'h8D
`define TTCU_IDX_T2_CTL 8'hC8
`define TTCU_IDX_T2_RCL 8'hCA
`define TTCU_IDX_T2_RCH 8'hCB
`define TTCU_IDX_T2_LOW 8'hCC
`define TTCU_IDX_T2_HIGH 8'hCD

// timer01_control bits
`define TTCU_C01_T1_FLAG 7
`define TTCU_C01_T1_RUN 6
`define TTCU_C01_T0_FLAG 5
`define TTCU_C01_T0_RUN 4

// timer01_mode_select bits
`define TTCU_M_T1_GATE 7
`define TTCU_M_T1_CSEL 6
`define TTCU_M_T1_MODE 4
`define TTCU_M_T0_GATE 3
`define TTCU_M_T0_CSEL 2
`define TTCU_M_T0_MODE 0

// timer2_control bits
`define TTCU_C2_FLAG 7
`define TTCU_C2_EXF 6
`define TTCU_C2_RXCLK 5
`define TTCU_C2_TXCLK 4
`define TTCU_C2_EXEN 3
`define TTCU_C2_RUN 2
`define TTCU_C2_CSEL 1
`define TTCU_C2_CAP 0

// reset values
`define TTCU_RST_BYTE 8'h00
`define TTCU_RST_WORD 32'h0000_0000
`define TTCU_PIN_IDLE 1'b1

`endif

// *** core/ttcu_pkg.sv ***
// Purpose: types shared by the timer/counter unit
// Assumes: nothing beyond the mode fields of the control registers
// Notes: timer 2 mode decode lives here as it is used by logic and checks
package ttcu_pkg;

	typedef enum logic [1:0] {
		ttcu_m13 = 2'b00,
		ttcu_m16 = 2'b01,
		ttcu_m8r = 2'b10,
		ttcu_msplit = 2'b11
	} ttcu_t01_mode_t;

	typedef enum logic [1:0] {
		ttcu_t2_off = 2'b00,
		ttcu_t2_auto = 2'b01,
		ttcu_t2_capt = 2'b10,
		ttcu_t2_baud = 2'b11
	} ttcu_t2_mode_t;

	// run, either clock select, capture select
	function automatic ttcu_t2_mode_t ttcu_t2_decode(logic run, logic rx, logic tx, logic cap);
		if (!run)
			return ttcu_t2_off;
		else if (rx | tx)
			return ttcu_t2_baud;
		else if (cap)
			return ttcu_t2_capt;
		else
			return ttcu_t2_auto;
	endfunction

endpackage

// *** core/ttcu_edge_sync.sv ***
// Purpose: pin synchroniser with falling edge detect
// Assumes: pin idles high
// Notes: edge pulse is one core cycle, two clocks after the pin falls
`timescale 1ns/1ps
`include "ttcu_defines.svh"
module ttcu_edge_sync (
	// clock and reset
	input logic ref_clk,
	input logic resetn,
	// pin and event
	input logic pin_level,
	output logic fall_pulse
);
	logic meta_q;
	logic sync_q;
	logic prev_q;

	// first stage only feeds second stage
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			meta_q <= `TTCU_PIN_IDLE;
			sync_q <= `TTCU_PIN_IDLE;
			prev_q <= `TTCU_PIN_IDLE;
		end else begin
			meta_q <= pin_level;
			sync_q <= meta_q;
			prev_q <= sync_q;
		end
	end

	// high then low on the synced level
	assign fall_pulse = prev_q & ~sync_q;
endmodule

// *** core/ttcu_top.sv ***
// Purpose: three timer/counters with an AHB-Lite register slave
// Assumes: pins synchronous except count and trigger pins, which are resynchronised
// Notes: zero wait state slave, response always OKAY
`timescale 1ns/1ps
`include "ttcu_defines.svh"
module ttcu_top
	import ttcu_pkg::*;
(
	// clock and reset
	input logic ref_clk,
	input logic resetn,
	// ahb-lite slave
	input logic hsel,
	input logic [31:0] haddr,
	input logic [1:0] htrans,
	input logic hwrite,
	input logic [2:0] hsize,
	input logic [31:0] hwdata,
	input logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	// external pins
	input logic ext_interrupt0_pin,
	input logic ext_interrupt1_pin,
	input logic timer0_count_pin,
	input logic timer1_count_pin,
	input logic timer2_count_pin,
	input logic timer2_trigger_pin,
	// flags and baud ticks
	output logic timer0_overflow_flag,
	output logic timer1_overflow_flag,
	output logic timer2_overflow_flag,
	output logic timer2_external_flag,
	output logic timer1_overflow_tick,
	output logic timer2_overflow_tick
);
	// bus state
	logic wr_q;
	logic [7:0] widx_q;
	logic [31:0] hrdata_q;
	logic hreadyout_q;
	logic hresp_q;
	logic [7:0] wd;
	// timer 0/1 registers
	logic timer0_run_q;
	logic timer1_run_q;
	logic timer0_overflow_flag_q;
	logic timer1_overflow_flag_q;
	logic [7:0] timer01_mode_select_q;
	logic [7:0] timer0_count_low_q;
	logic [7:0] timer0_count_high_q;
	logic [7:0] timer1_count_low_q;
	logic [7:0] timer1_count_high_q;
	logic timer1_tick_q;
	// timer 2 registers
	logic [7:0] timer2_control_q;
	logic [7:0] timer2_reload_capture_low_q;
	logic [7:0] timer2_reload_capture_high_q;
	logic [7:0] timer2_count_low_q;
	logic [7:0] timer2_count_high_q;
	logic timer2_tick_q;
	// pin events
	logic [3:0] pin_vec;
	logic [3:0] fall;
	// next state
	ttcu_t01_mode_t mode0;
	ttcu_t01_mode_t mode1;
	ttcu_t2_mode_t t2m;
	logic inc0_lo;
	logic inc0_hi;
	logic inc1;
	logic ovf0_hi;
	logic [16:0] st0;
	logic [16:0] st1;
	logic [7:0] th0_d;
	logic set1;
	logic inc2;
	logic ovf2;
	logic trig;
	logic trig_cap;
	logic trig_rel;
	logic [15:0] cnt2;
	logic [15:0] cnt2_d;

	// data-phase write hit
	function automatic logic wr_hit(logic [7:0] idx);
		return wr_q && (widx_q == idx);
	endfunction

	// one counting step of timer 0 or 1: {overflow, high, low}
	function automatic logic [16:0] ttcu_step(ttcu_t01_mode_t m, logic [7:0] lo, logic [7:0] hi, logic inc);
		logic [12:0] c13;
		logic [15:0] c16;
		c13 = {hi, lo[4:0]};
		c16 = {hi, lo};
		if (!inc)
			return {1'b0, hi, lo};
		case (m)
			ttcu_m13: begin
				c13 = c13 + 13'h0001;
				return {(c13 == 13'h0000), c13[12:5], lo[7:5], c13[4:0]};
			end
			ttcu_m16: begin
				c16 = c16 + 16'h0001;
				return {(c16 == 16'h0000), c16};
			end
			ttcu_m8r: begin
				if (lo == 8'hFF)
					return {1'b1, hi, hi};
				return {1'b0, hi, lo + 8'h01};
			end
			default: begin
				return {(lo == 8'hFF), hi, lo + 8'h01};
			end
		endcase
	endfunction

	assign pin_vec = {timer2_trigger_pin, timer2_count_pin, timer1_count_pin, timer0_count_pin};
	genvar gi;
	generate
		for (gi = 0; gi < 4; gi++) begin : g_sync
			ttcu_edge_sync u_sync (
				.ref_clk(ref_clk),
				.resetn(resetn),
				.pin_level(pin_vec[gi]),
				.fall_pulse(fall[gi])
			);
		end
	endgenerate

	// timer 0/1 step decisions
	always_comb begin
		mode0 = ttcu_t01_mode_t'(timer01_mode_select_q[`TTCU_M_T0_MODE +: 2]);
		mode1 = ttcu_t01_mode_t'(timer01_mode_select_q[`TTCU_M_T1_MODE +: 2]);
		// run and gate; every cycle in timer function
		inc0_lo = timer0_run_q
			& (~timer01_mode_select_q[`TTCU_M_T0_GATE] | ext_interrupt0_pin)
			& (timer01_mode_select_q[`TTCU_M_T0_CSEL] ? fall[0] : 1'b1);
		inc1 = timer1_run_q & (mode1 != ttcu_msplit)
			& (~timer01_mode_select_q[`TTCU_M_T1_GATE] | ext_interrupt1_pin)
			& (timer01_mode_select_q[`TTCU_M_T1_CSEL] ? fall[1] : 1'b1);
		// split high byte runs on timer 1 run bit
		inc0_hi = (mode0 == ttcu_msplit) & timer1_run_q;
		ovf0_hi = inc0_hi & (timer0_count_high_q == 8'hFF);
		st0 = ttcu_step(mode0, timer0_count_low_q, timer0_count_high_q, inc0_lo);
		st1 = ttcu_step(mode1, timer1_count_low_q, timer1_count_high_q, inc1);
		th0_d = st0[15:8];
		if (mode0 == ttcu_msplit)
			th0_d = timer0_count_high_q + {7'h00, inc0_hi};
		// high byte takes over timer 1 flag
		set1 = (mode0 == ttcu_msplit) ? ovf0_hi : st1[16];
	end

	// timer 2 step decisions
	always_comb begin
		t2m = ttcu_t2_decode(timer2_control_q[`TTCU_C2_RUN], timer2_control_q[`TTCU_C2_RXCLK],
			timer2_control_q[`TTCU_C2_TXCLK], timer2_control_q[`TTCU_C2_CAP]);
		cnt2 = {timer2_count_high_q, timer2_count_low_q};
		inc2 = (t2m != ttcu_t2_off) & (timer2_control_q[`TTCU_C2_CSEL] ? fall[2] : 1'b1);
		ovf2 = inc2 & (cnt2 == 16'hFFFF);
		trig = fall[3] & timer2_control_q[`TTCU_C2_EXEN];
		// capture only when no serial clock select
		trig_cap = trig & timer2_control_q[`TTCU_C2_CAP]
			& ~(timer2_control_q[`TTCU_C2_RXCLK] | timer2_control_q[`TTCU_C2_TXCLK]);
		// reload only in plain autoreload configuration
		trig_rel = trig & ~timer2_control_q[`TTCU_C2_CAP]
			& ~(timer2_control_q[`TTCU_C2_RXCLK] | timer2_control_q[`TTCU_C2_TXCLK]);
		cnt2_d = cnt2 + {15'h0000, inc2};
		// rollover reload; capture mode never reloads
		if (trig_rel | (ovf2 & (t2m != ttcu_t2_capt)))
			cnt2_d = {timer2_reload_capture_high_q, timer2_reload_capture_low_q};
	end

	assign wd = hwdata[7:0];

	// address phase capture and read data; zero wait states
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			wr_q <= 1'b0;
			widx_q <= `TTCU_RST_BYTE;
			hrdata_q <= `TTCU_RST_WORD;
			hreadyout_q <= 1'b1;
			hresp_q <= 1'b0;
		end else begin
			hreadyout_q <= 1'b1;
			hresp_q <= 1'b0;
			wr_q <= 1'b0;
			if (hsel && htrans[1] && hready) begin
				// unmapped or misaligned words read zero and drop writes
				wr_q <= hwrite && (haddr[31:10] == 22'h000000) && (haddr[1:0] == 2'b00);
				widx_q <= haddr[9:2];
				hrdata_q <= {24'h000000, rd_byte(haddr)};
			end
		end
	end

	// read mux; low nibble of timer01_control is not ours and reads zero
	function automatic logic [7:0] rd_byte(logic [31:0] a);
		if ((a[31:10] != 22'h000000) || (a[1:0] != 2'b00))
			return `TTCU_RST_BYTE;
		case (a[9:2])
			`TTCU_IDX_T01_CTL: return {timer1_overflow_flag_q, timer1_run_q,
				timer0_overflow_flag_q, timer0_run_q, 4'h0};
			`TTCU_IDX_T01_MODE: return timer01_mode_select_q;
			`TTCU_IDX_T0_LOW: return timer0_count_low_q;
			`TTCU_IDX_T1_LOW: return timer1_count_low_q;
			`TTCU_IDX_T0_HIGH: return timer0_count_high_q;
			`TTCU_IDX_T1_HIGH: return timer1_count_high_q;
			`TTCU_IDX_T2_CTL: return timer2_control_q;
			`TTCU_IDX_T2_RCL: return timer2_reload_capture_low_q;
			`TTCU_IDX_T2_RCH: return timer2_reload_capture_high_q;
			`TTCU_IDX_T2_LOW: return timer2_count_low_q;
			`TTCU_IDX_T2_HIGH: return timer2_count_high_q;
			default: return `TTCU_RST_BYTE;
		endcase
	endfunction

	// timer 0/1 control and mode; a hardware set beats a software clear
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			timer0_run_q <= 1'b0;
			timer1_run_q <= 1'b0;
			timer0_overflow_flag_q <= 1'b0;
			timer1_overflow_flag_q <= 1'b0;
			timer01_mode_select_q <= `TTCU_RST_BYTE;
		end else begin
			if (wr_hit(`TTCU_IDX_T01_CTL)) begin
				timer0_run_q <= wd[`TTCU_C01_T0_RUN];
				timer1_run_q <= wd[`TTCU_C01_T1_RUN];
			end
			timer0_overflow_flag_q <= (wr_hit(`TTCU_IDX_T01_CTL) ? wd[`TTCU_C01_T0_FLAG]
				: timer0_overflow_flag_q) | st0[16];
			timer1_overflow_flag_q <= (wr_hit(`TTCU_IDX_T01_CTL) ? wd[`TTCU_C01_T1_FLAG]
				: timer1_overflow_flag_q) | set1;
			if (wr_hit(`TTCU_IDX_T01_MODE))
				timer01_mode_select_q <= wd;
		end
	end

	// timer 0 count bytes; a software write wins over the step
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			timer0_count_low_q <= `TTCU_RST_BYTE;
			timer0_count_high_q <= `TTCU_RST_BYTE;
		end else begin
			timer0_count_low_q <= wr_hit(`TTCU_IDX_T0_LOW) ? wd : st0[7:0];
			timer0_count_high_q <= wr_hit(`TTCU_IDX_T0_HIGH) ? wd : th0_d;
		end
	end

	// timer 1 count bytes and baud tick
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			timer1_count_low_q <= `TTCU_RST_BYTE;
			timer1_count_high_q <= `TTCU_RST_BYTE;
			timer1_tick_q <= 1'b0;
		end else begin
			timer1_count_low_q <= wr_hit(`TTCU_IDX_T1_LOW) ? wd : st1[7:0];
			timer1_count_high_q <= wr_hit(`TTCU_IDX_T1_HIGH) ? wd : st1[15:8];
			// tick survives loss of the flag to timer 0
			timer1_tick_q <= st1[16];
		end
	end

	// timer 2 control and flags
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			timer2_control_q <= `TTCU_RST_BYTE;
		end else begin
			if (wr_hit(`TTCU_IDX_T2_CTL))
				timer2_control_q <= wd;
			// no overflow flag in baud mode; hardware only sets
			timer2_control_q[`TTCU_C2_FLAG] <= (wr_hit(`TTCU_IDX_T2_CTL) ? wd[`TTCU_C2_FLAG]
				: timer2_control_q[`TTCU_C2_FLAG]) | (ovf2 & (t2m != ttcu_t2_baud));
			// trigger edge sets external flag in every mode
			timer2_control_q[`TTCU_C2_EXF] <= (wr_hit(`TTCU_IDX_T2_CTL) ? wd[`TTCU_C2_EXF]
				: timer2_control_q[`TTCU_C2_EXF]) | trig;
		end
	end

	// timer 2 count, reload/capture registers and baud tick
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			timer2_count_low_q <= `TTCU_RST_BYTE;
			timer2_count_high_q <= `TTCU_RST_BYTE;
			timer2_reload_capture_low_q <= `TTCU_RST_BYTE;
			timer2_reload_capture_high_q <= `TTCU_RST_BYTE;
			timer2_tick_q <= 1'b0;
		end else begin
			timer2_count_low_q <= wr_hit(`TTCU_IDX_T2_LOW) ? wd : cnt2_d[7:0];
			timer2_count_high_q <= wr_hit(`TTCU_IDX_T2_HIGH) ? wd : cnt2_d[15:8];
			if (wr_hit(`TTCU_IDX_T2_RCL))
				timer2_reload_capture_low_q <= wd;
			else if (trig_cap)
				timer2_reload_capture_low_q <= timer2_count_low_q;
			if (wr_hit(`TTCU_IDX_T2_RCH))
				timer2_reload_capture_high_q <= wd;
			else if (trig_cap)
				timer2_reload_capture_high_q <= timer2_count_high_q;
			timer2_tick_q <= ovf2;
		end
	end

	// outputs
	assign hrdata = hrdata_q;
	assign hreadyout = hreadyout_q;
	assign hresp = hresp_q;
	assign timer0_overflow_flag = timer0_overflow_flag_q;
	assign timer1_overflow_flag = timer1_overflow_flag_q;
	assign timer2_overflow_flag = timer2_control_q[`TTCU_C2_FLAG];
	assign timer2_external_flag = timer2_control_q[`TTCU_C2_EXF];
	assign timer1_overflow_tick = timer1_tick_q;
	assign timer2_overflow_tick = timer2_tick_q;

	// checks; each assumes no register write lands in the same cycle
	property p_thirteen;
		@(posedge ref_clk) disable iff (!resetn)
		(!wr_q && mode0 == ttcu_m13 && inc0_lo) |=>
			({timer0_count_high_q, timer0_count_low_q[4:0]}
			== $past({timer0_count_high_q, timer0_count_low_q[4:0]}) + 13'h0001)
			&& $stable(timer0_count_low_q[7:5]);
	endproperty
	a_thirteen: assert property (p_thirteen) else $error("13-bit step wrong");

	property p_flag0;
		@(posedge ref_clk) disable iff (!resetn)
		(!wr_q && inc0_lo && mode0 == ttcu_m16 && timer0_count_low_q == 8'hFF
			&& timer0_count_high_q == 8'hFF) |=> timer0_overflow_flag_q ##1 timer0_overflow_flag;
	endproperty
	a_flag0: assert property (p_flag0) else $error("timer 0 flag not set on wrap");

	property p_gate;
		@(posedge ref_clk) disable iff (!resetn)
		(!wr_q && timer01_mode_select_q[`TTCU_M_T0_GATE] && !ext_interrupt0_pin)
			|=> $stable(timer0_count_low_q);
	endproperty
	a_gate: assert property (p_gate) else $error("gated timer 0 moved");

	property p_sixteen;
		@(posedge ref_clk) disable iff (!resetn)
		(!wr_q && mode0 == ttcu_m16 && timer0_run_q && !timer01_mode_select_q[`TTCU_M_T0_GATE]
			&& !timer01_mode_select_q[`TTCU_M_T0_CSEL]) |=>
			{timer0_count_high_q, timer0_count_low_q}
			== $past({timer0_count_high_q, timer0_count_low_q}) + 16'h0001;
	endproperty
	a_sixteen: assert property (p_sixteen) else $error("timer 0 not one step per cycle");

	property p_reload8;
		@(posedge ref_clk) disable iff (!resetn)
		(!wr_q && mode0 == ttcu_m8r && inc0_lo && timer0_count_low_q == 8'hFF) |=>
			timer0_count_low_q == $past(timer0_count_high_q) && $stable(timer0_count_high_q)
			&& timer0_overflow_flag_q;
	endproperty
	a_reload8: assert property (p_reload8) else $error("mode 2 reload wrong");

	property p_hold1;
		@(posedge ref_clk) disable iff (!resetn)
		(!wr_q && mode1 == ttcu_msplit)[*2] |-> $stable({timer1_count_high_q, timer1_count_low_q});
	endproperty
	a_hold1: assert property (p_hold1) else $error("timer 1 moved in mode 3");

	property p_split_high;
		@(posedge ref_clk) disable iff (!resetn)
		(!wr_q && mode0 == ttcu_msplit && timer1_run_q && timer0_count_high_q == 8'hFF)
			|=> timer1_overflow_flag_q && timer0_count_high_q == 8'h00;
	endproperty
	a_split_high: assert property (p_split_high) else $error("split high byte flag missing");

	property p_auto2;
		@(posedge ref_clk) disable iff (!resetn)
		(!wr_q && t2m == ttcu_t2_auto && ovf2) |=> timer2_overflow_flag
			&& {timer2_count_high_q, timer2_count_low_q}
			== $past({timer2_reload_capture_high_q, timer2_reload_capture_low_q});
	endproperty
	a_auto2: assert property (p_auto2) else $error("timer 2 reload wrong");

	property p_capture;
		@(posedge ref_clk) disable iff (!resetn)
		(!wr_q && trig_cap) |=> timer2_external_flag
			&& {timer2_reload_capture_high_q, timer2_reload_capture_low_q}
			== $past({timer2_count_high_q, timer2_count_low_q});
	endproperty
	a_capture: assert property (p_capture) else $error("timer 2 capture wrong");

	property p_baud;
		@(posedge ref_clk) disable iff (!resetn)
		(!wr_q && t2m == ttcu_t2_baud && !timer2_overflow_flag) |=> !timer2_overflow_flag;
	endproperty
	a_baud: assert property (p_baud) else $error("overflow flag set in baud mode");

	property p_sticky2;
		@(posedge ref_clk) disable iff (!resetn)
		(!wr_q && timer2_overflow_flag) |=> timer2_overflow_flag;
	endproperty
	a_sticky2: assert property (p_sticky2) else $error("timer 2 flag cleared by hardware");
endmodule

// *** testbench/ttcu_pin_model.sv ***
// Purpose: far side pins of the timer unit, count and trigger sources
// Assumes: every pin idles high and goes back high once released
// Notes: pulses stay low two cycles so the resynchroniser cannot miss them
`timescale 1ns/1ps
module ttcu_pin_model (
	// clock
	input logic ref_clk,
	// pins
	output logic timer0_count_pin,
	output logic timer1_count_pin,
	output logic timer2_count_pin,
	output logic timer2_trigger_pin
);
	// idle level on every pin
	initial begin
		timer0_count_pin = 1'b1;
		timer1_count_pin = 1'b1;
		timer2_count_pin = 1'b1;
		timer2_trigger_pin = 1'b1;
	end
	// one falling edge per call: 0/1 timer 0/1 count, 2 timer 2 count, 3 trigger
	task automatic pulse(input logic [1:0] which);
		@(posedge ref_clk);
		case (which)
			2'h0: timer0_count_pin <= 1'b0;
			2'h1: timer1_count_pin <= 1'b0;
			2'h2: timer2_count_pin <= 1'b0;
			default: timer2_trigger_pin <= 1'b0;
		endcase
		repeat (2) @(posedge ref_clk);
		timer2_trigger_pin <= 1'b1; // released pins return high
		timer2_count_pin <= 1'b1;
		timer0_count_pin <= 1'b1;
		timer1_count_pin <= 1'b1;
		repeat (2) @(posedge ref_clk);
	endtask
endmodule

// *** testbench/test_triple_timer_counter_unit.sv ***
// Purpose: self-checking bench of the timer unit over its register bus
// Assumes: zero wait state slave, counts stopped by gating so flags survive
// Notes: a count run started at edge E and stopped by a write steps n+3 times
`timescale 1ns/1ps
`include "ttcu_defines.svh"
module test_triple_timer_counter_unit;
	typedef struct packed {
		logic t;
		logic [7:0] m, hi, lo;
		logic [3:0] n;
		logic [7:0] ehi, elo;
		logic ef;
	} ttcu_row_t;
	logic ref_clk, resetn, hsel, hwrite, hready, hreadyout, hresp;
	logic [31:0] haddr, hwdata, hrdata;
	logic [1:0] htrans;
	logic [2:0] hsize;
	logic ext0, ext1, c0, c1, c2, trg, f0, f1, f2, fx, tk1, tk2;
	int errors = 0;
	int n_compared = 0;
	int n_tk1 = 0;
	int n_tk2 = 0;
	ttcu_row_t r;
	logic [7:0] m8;
	logic [7:0] regs [11] = '{8'h88, 8'h89, 8'h8A, 8'h8B, 8'h8C, 8'h8D, 8'hC8, 8'hCA, 8'hCB, 8'hCC, 8'hCD};
	// timer sel, mode, high, low, idle cycles, expected high, low, flag
	ttcu_row_t rows [7] = '{
		'{1'b0, 8'h01, 8'hFF, 8'hFE, 4'h0, 8'h00, 8'h01, 1'b1},
		'{1'b0, 8'h00, 8'hFF, 8'h1F, 4'h0, 8'h00, 8'h02, 1'b1},
		'{1'b0, 8'h02, 8'hA0, 8'hFF, 4'h1, 8'hA0, 8'hA3, 1'b1},
		'{1'b0, 8'h01, 8'h12, 8'h34, 4'h5, 8'h12, 8'h3C, 1'b0},
		'{1'b0, 8'h09, 8'h12, 8'h34, 4'h5, 8'h12, 8'h34, 1'b0},
		'{1'b1, 8'h01, 8'hFF, 8'hFF, 4'h0, 8'h00, 8'h02, 1'b1},
		'{1'b1, 8'h03, 8'h55, 8'h66, 4'h3, 8'h55, 8'h66, 1'b0}
	};
	// the one slave drives the bus ready
	assign hready = hreadyout;
	ttcu_top u_ttcu_top (.ref_clk(ref_clk), .resetn(resetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
		.hreadyout(hreadyout), .hresp(hresp), .ext_interrupt0_pin(ext0), .ext_interrupt1_pin(ext1),
		.timer0_count_pin(c0), .timer1_count_pin(c1), .timer2_count_pin(c2), .timer2_trigger_pin(trg),
		.timer0_overflow_flag(f0), .timer1_overflow_flag(f1), .timer2_overflow_flag(f2),
		.timer2_external_flag(fx), .timer1_overflow_tick(tk1), .timer2_overflow_tick(tk2));
	ttcu_pin_model u_ttcu_pin_model (.ref_clk(ref_clk), .timer0_count_pin(c0), .timer1_count_pin(c1),
		.timer2_count_pin(c2), .timer2_trigger_pin(trg));
	// free running 50 MHz clock
	initial begin
		ref_clk = 1'b0;
		forever #10 ref_clk = ~ref_clk;
	end
	// ticks counted per sampled high cycle, so a stretched pulse counts twice
	always @(posedge ref_clk) begin
		n_tk1 <= n_tk1 + int'(tk1 === 1'b1);
		n_tk2 <= n_tk2 + int'(tk2 === 1'b1);
	end
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			errors++;
			$display("BAD %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	// one single word transfer, waits on ready rather than assuming a latency
	task automatic bus(input logic wr, input logic [7:0] idx, input logic [7:0] d, output logic [31:0] q);
		@(posedge ref_clk);
		hsel <= 1'b1;
		haddr <= {22'h0, idx, 2'b00};
		hwrite <= wr;
		htrans <= 2'b10;
		do @(posedge ref_clk); while (hreadyout !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'b00;
		hwdata <= {24'h0, d};
		do @(posedge ref_clk); while (hreadyout !== 1'b1);
		q = hrdata;
	endtask
	task automatic wr(input logic [7:0] idx, input logic [7:0] d);
		logic [31:0] q;
		bus(1'b1, idx, d, q);
	endtask
	task automatic rdc(input logic [7:0] idx, input logic [7:0] e);
		logic [31:0] q;
		bus(1'b0, idx, 8'h00, q);
		chk(q, {24'h0, e});
	endtask
	task automatic finish_test;
		if (errors == 0 && n_compared > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	// watchdog, far beyond the few hundred cycles the run needs
	initial begin
		#400000;
		errors++;
		finish_test();
	end
	initial begin
		{resetn, hsel, hwrite, ext0, ext1} = 5'h0;
		{haddr, hwdata} = 64'h0;
		htrans = 2'b00;
		hsize = 3'b010;
		repeat (16) @(posedge ref_clk);
		resetn <= 1'b1;
		foreach (regs[i])
			rdc(regs[i], 8'h00); // register reset values
		wr(8'h90, 8'h55);
		rdc(8'h90, 8'h00); // unmapped address drops writes
		// stop by setting the gate bit while the gate pins are low, keeping flags
		foreach (rows[i]) begin
			r = rows[i];
			m8 = r.t ? {r.m[3:0], 4'h0} : r.m;
			wr(`TTCU_IDX_T01_CTL, 8'h00);
			wr(`TTCU_IDX_T01_MODE, m8);
			wr(r.t ? `TTCU_IDX_T1_HIGH : `TTCU_IDX_T0_HIGH, r.hi);
			wr(r.t ? `TTCU_IDX_T1_LOW : `TTCU_IDX_T0_LOW, r.lo);
			wr(`TTCU_IDX_T01_CTL, r.t ? 8'h40 : 8'h10);
			repeat (r.n) @(posedge ref_clk);
			wr(`TTCU_IDX_T01_MODE, m8 | (r.t ? 8'h80 : 8'h08));
			@(negedge ref_clk);
			chk(32'(r.t ? f1 : f0), 32'(r.ef));
			rdc(r.t ? `TTCU_IDX_T1_HIGH : `TTCU_IDX_T0_HIGH, r.ehi);
			rdc(r.t ? `TTCU_IDX_T1_LOW : `TTCU_IDX_T0_LOW, r.elo);
		end
		// only the timer 1 wrap row gives a baud tick
		chk(n_tk1, 32'h1);
		// gate held open by the pin, closed when it drops
		wr(`TTCU_IDX_T0_LOW, 8'h00);
		wr(`TTCU_IDX_T01_MODE, 8'h09);
		ext0 <= 1'b1;
		wr(`TTCU_IDX_T01_CTL, 8'h10);
		repeat (3) @(posedge ref_clk);
		ext0 <= 1'b0;
		wr(`TTCU_IDX_T01_CTL, 8'h00);
		rdc(`TTCU_IDX_T0_LOW, 8'h03);
		// timer 0 counter function steps once per pin falling edge
		wr(`TTCU_IDX_T01_MODE, 8'h05);
		wr(`TTCU_IDX_T0_LOW, 8'h00);
		wr(`TTCU_IDX_T01_CTL, 8'h10);
		repeat (2) u_ttcu_pin_model.pulse(2'h0);
		repeat (4) @(posedge ref_clk);
		wr(`TTCU_IDX_T01_CTL, 8'h00);
		rdc(`TTCU_IDX_T0_LOW, 8'h02);
		// split mode, both halves wrap
		wr(`TTCU_IDX_T01_MODE, 8'h03);
		wr(`TTCU_IDX_T0_LOW, 8'hFE);
		wr(`TTCU_IDX_T0_HIGH, 8'hFF);
		wr(`TTCU_IDX_T01_CTL, 8'h50);
		repeat (3) @(posedge ref_clk);
		@(negedge ref_clk);
		chk(32'(f0), 32'h1);
		chk(32'(f1), 32'h1);
		wr(`TTCU_IDX_T01_CTL, 8'hA0);
		rdc(`TTCU_IDX_T0_LOW, 8'h04);
		rdc(`TTCU_IDX_T0_HIGH, 8'h05);
		// timer 2 autoreload from FFFE
		wr(`TTCU_IDX_T2_RCL, 8'h34);
		wr(`TTCU_IDX_T2_RCH, 8'h12);
		wr(`TTCU_IDX_T2_LOW, 8'hFE);
		wr(`TTCU_IDX_T2_HIGH, 8'hFF);
		wr(`TTCU_IDX_T2_CTL, 8'h04);
		repeat (3) @(posedge ref_clk);
		@(negedge ref_clk);
		chk(32'(f2), 32'h1);
		wr(`TTCU_IDX_T2_CTL, 8'h80);
		rdc(`TTCU_IDX_T2_LOW, 8'h38);
		rdc(`TTCU_IDX_T2_HIGH, 8'h12);
		chk(32'(f2), 32'h1);
		wr(`TTCU_IDX_T2_CTL, 8'h00);
		@(negedge ref_clk);
		chk(32'(f2), 32'h0);
		// capture on trigger with the timer stopped
		wr(`TTCU_IDX_T2_CTL, 8'h09);
		wr(`TTCU_IDX_T2_RCL, 8'h00);
		wr(`TTCU_IDX_T2_RCH, 8'h00);
		u_ttcu_pin_model.pulse(2'h3);
		repeat (4) @(posedge ref_clk);
		rdc(`TTCU_IDX_T2_RCL, 8'h38);
		rdc(`TTCU_IDX_T2_RCH, 8'h12);
		chk(32'(fx), 32'h1);
		// capture mode wraps freely, no reload
		wr(`TTCU_IDX_T2_LOW, 8'hFE);
		wr(`TTCU_IDX_T2_HIGH, 8'hFF);
		wr(`TTCU_IDX_T2_CTL, 8'h05);
		wr(`TTCU_IDX_T2_CTL, 8'h81);
		rdc(`TTCU_IDX_T2_LOW, 8'h01);
		rdc(`TTCU_IDX_T2_HIGH, 8'h00);
		chk(32'(f2), 32'h1);
		// trigger forces the reload in autoreload configuration with the timer stopped
		wr(`TTCU_IDX_T2_CTL, 8'h08);
		u_ttcu_pin_model.pulse(2'h3);
		repeat (4) @(posedge ref_clk);
		rdc(`TTCU_IDX_T2_LOW, 8'h38);
		rdc(`TTCU_IDX_T2_HIGH, 8'h12);
		chk(32'(fx), 32'h1);
		// baud mode wraps without the overflow flag
		wr(`TTCU_IDX_T2_LOW, 8'hFE);
		wr(`TTCU_IDX_T2_HIGH, 8'hFF);
		wr(`TTCU_IDX_T2_CTL, 8'h1C);
		u_ttcu_pin_model.pulse(2'h3);
		repeat (4) @(posedge ref_clk);
		chk(32'(f2), 32'h0);
		// one tick each from the autoreload, capture and baud wraps
		chk(n_tk2, 32'h3);
		chk(32'(fx), 32'h1);
		// counter function counts pin edges only
		wr(`TTCU_IDX_T2_CTL, 8'h00);
		wr(`TTCU_IDX_T2_LOW, 8'h00);
		wr(`TTCU_IDX_T2_HIGH, 8'h00);
		wr(`TTCU_IDX_T2_CTL, 8'h06);
		repeat (3) u_ttcu_pin_model.pulse(2'h2);
		repeat (4) @(posedge ref_clk);
		wr(`TTCU_IDX_T2_CTL, 8'h00);
		rdc(`TTCU_IDX_T2_LOW, 8'h03);
		rdc(`TTCU_IDX_T2_HIGH, 8'h00);
		// mid-run reset clears the set timer 0/1 flags and the capture byte
		resetn <= 1'b0;
		repeat (2) @(posedge ref_clk);
		chk(32'({f0, f1, f2, fx, tk1, tk2, hresp}), 32'h0);
		resetn <= 1'b1;
		rdc(`TTCU_IDX_T01_CTL, 8'h00);
		rdc(`TTCU_IDX_T2_RCH, 8'h00);
		finish_test();
	end
endmodule
